// ---- verilog/cdsl_loader.sv ----
// Purpose: three-wire serial loader for three control DACs and a flag pin
// Assumes: serial pins are asynchronous, sampled on CLOCK after two flops
// Notes:   Wishbone gives read-back of DAC codes and loader state; writes ack, no effect
// Function
// - shift 16 bits MSB first on falling clock
// - bits 0-9 data, 10-15 control
// - DAC widths: A 9, B 10, C 8
// - strobe rising edge updates DACs and flag
// - several selects load same data together
// - bit10 C, bit11 A, bit12 B
// - bit 15 sets flag level
// - bit 14 enables flag driver
// - all-ones or all-zeros code means low power
// - independent of transmit and receive sleep
`timescale 1ns/1ps
`default_nettype none
module cdsl_loader
    import cdsl_pkg::*;
(
    input  wire logic                    CLOCK,
    input  wire logic                    SRST,
    input  wire logic                    SER_CLK,
    input  wire logic                    SER_DATA,
    input  wire logic                    SER_LOAD_N,
    output var  logic [CDSL_DAC_A_W-1:0] CONTROL_DAC_A,
    output var  logic [CDSL_DAC_B_W-1:0] CONTROL_DAC_B,
    output var  logic [CDSL_DAC_C_W-1:0] CONTROL_DAC_C,
    output var  logic [2:0]              DAC_LOW_POWER,
    output var  logic                    FLAG_O,
    output var  logic                    FLAG_OE,
    input  wire logic                    WB_CYC_I,
    input  wire logic                    WB_STB_I,
    input  wire logic                    WB_WE_I,
    input  wire logic [3:0]              WB_ADR_I,
    input  wire logic [3:0]              WB_SEL_I,
    input  wire logic [31:0]             WB_DAT_I,
    output var  logic                    WB_ACK_O,
    output var  logic [31:0]             WB_DAT_O
);
    typedef struct packed {
        logic [CDSL_WORD_W-1:0]  shift;
        logic [4:0]              count;
        logic                    clk_prev;
        logic                    load_prev;
        logic [CDSL_DAC_A_W-1:0] dac_a;
        logic [CDSL_DAC_B_W-1:0] dac_b;
        logic [CDSL_DAC_C_W-1:0] dac_c;
        logic [2:0]              lowp;
        logic                    flag;
        logic                    flag_oe;
        logic                    updated;
    } cdsl_state_t;

    cdsl_state_t s_q, s_d;
    logic [2:0]  pins_s;
    logic        sclk_s, sdat_s, sload_n_s;
    logic [CDSL_DATA_W-1:0] data_f;
    logic [9:0]  ra, rb, rc;
    logic [7:0]  status;

    // pins cross into CLOCK before anything looks at them
    // clock and strobe idle high: they cross inverted so that the cleared
    // synchroniser reads as idle and no false edge follows reset
    cdsl_sync #(.W(3)) u_sync (
        .clk  (CLOCK),
        .srst (SRST),
        .d    ({~SER_CLK, SER_DATA, ~SER_LOAD_N}),
        .q    (pins_s)
    );
    assign sclk_s    = ~pins_s[2];
    assign sdat_s    = pins_s[1];
    assign sload_n_s = ~pins_s[0];
    assign data_f    = s_q.shift[CDSL_DATA_W-1:0];

    always_comb begin
        s_d           = s_q;
        s_d.clk_prev  = sclk_s;
        s_d.load_prev = sload_n_s;
        s_d.updated   = 1'b0;
        // falling edge of the serial clock while strobe low
        if (!sload_n_s && s_q.clk_prev && !sclk_s) begin
            s_d.shift = {s_q.shift[CDSL_WORD_W-2:0], sdat_s};
            if (s_q.count != 5'(CDSL_WORD_W)) begin
                s_d.count = s_q.count + 5'h01;
            end
        end
        // strobe rising edge commits the word; short words still commit the
        // last 16 bits shifted, which is what the pin-level part would do
        if (!s_q.load_prev && sload_n_s) begin
            if (s_q.shift[CDSL_SEL_A_BIT]) begin
                s_d.dac_a = data_f[CDSL_DAC_A_W-1:0];
            end
            if (s_q.shift[CDSL_SEL_B_BIT]) begin
                s_d.dac_b = data_f[CDSL_DAC_B_W-1:0];
            end
            if (s_q.shift[CDSL_SEL_C_BIT]) begin
                s_d.dac_c = data_f[CDSL_DAC_C_W-1:0];
            end
            s_d.flag    = s_q.shift[CDSL_FLAG_LV_BIT];
            s_d.flag_oe = s_q.shift[CDSL_FLAG_EN_BIT];
            s_d.count   = CDSL_CNT_RST;
            s_d.updated = 1'b1;
        end
        // low-power indication follows the held codes only
        s_d.lowp[0] = (&s_d.dac_a) || (s_d.dac_a == '0);
        s_d.lowp[1] = (&s_d.dac_b) || (s_d.dac_b == '0);
        s_d.lowp[2] = (&s_d.dac_c) || (s_d.dac_c == '0);
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            s_q       <= '0;
            s_q.lowp  <= 3'h7;
            s_q.shift <= CDSL_WORD_RST;
            s_q.clk_prev  <= 1'b1;
            s_q.load_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign ra     = {1'b0, s_q.dac_a};
    assign rb     = s_q.dac_b;
    assign rc     = {2'h0, s_q.dac_c};
    assign status = {s_q.count, s_q.flag_oe, s_q.flag, s_q.updated};

    cdsl_wb_slave u_wb (
        .clk    (CLOCK),
        .srst   (SRST),
        .cyc    (WB_CYC_I),
        .stb    (WB_STB_I),
        .adr    (WB_ADR_I),
        .dac_a  (ra),
        .dac_b  (rb),
        .dac_c  (rc),
        .status (status),
        .ack    (WB_ACK_O),
        .dat    (WB_DAT_O)
    );

    assign CONTROL_DAC_A = s_q.dac_a;
    assign CONTROL_DAC_B = s_q.dac_b;
    assign CONTROL_DAC_C = s_q.dac_c;
    assign DAC_LOW_POWER = s_q.lowp;
    assign FLAG_O        = s_q.flag;
    assign FLAG_OE       = s_q.flag_oe;
endmodule : cdsl_loader
`default_nettype wire

// ---- verilog/cdsl_pkg.sv ----
// Purpose: shared constants for the control DAC serial loader
// Assumes: 16-bit serial word, MSB first, Wishbone register access
// Notes:   offsets are byte addresses of 32-bit words
package cdsl_pkg;
    localparam int          CDSL_WORD_W      = 16;
    localparam int          CDSL_DATA_W      = 10;
    localparam int          CDSL_DAC_A_W     = 9;
    localparam int          CDSL_DAC_B_W     = 10;
    localparam int          CDSL_DAC_C_W     = 8;
    localparam int          CDSL_SEL_C_BIT   = 10;
    localparam int          CDSL_SEL_A_BIT   = 11;
    localparam int          CDSL_SEL_B_BIT   = 12;
    localparam int          CDSL_FLAG_EN_BIT = 14;
    localparam int          CDSL_FLAG_LV_BIT = 15;
    localparam logic [3:0]  CDSL_ADR_W       = 4'h4;
    localparam logic [3:0]  CDSL_OFS_DAC_A   = 4'h0;
    localparam logic [3:0]  CDSL_OFS_DAC_B   = 4'h4;
    localparam logic [3:0]  CDSL_OFS_DAC_C   = 4'h8;
    localparam logic [3:0]  CDSL_OFS_STATUS  = 4'hC;
    localparam logic [4:0]  CDSL_CNT_RST     = 5'h00;
    localparam logic [15:0] CDSL_WORD_RST    = 16'h0000;
endpackage : cdsl_pkg

// ---- verilog/cdsl_sync.sv ----
// Purpose: two-flop synchroniser for pin inputs
// Assumes: input is asynchronous to CLOCK
// Notes:   first stage read only by second stage
`timescale 1ns/1ps
`default_nettype none
module cdsl_sync #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : cdsl_sync
`default_nettype wire

// ---- verilog/cdsl_wb_slave.sv ----
// Purpose: classic Wishbone read-only register window
// Assumes: single-cycle classic transfers, 32-bit data
// Notes:   ack one cycle after request, dropped next cycle
`timescale 1ns/1ps
`default_nettype none
module cdsl_wb_slave
    import cdsl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        cyc,
    input  wire logic        stb,
    input  wire logic [3:0]  adr,
    input  wire logic [9:0]  dac_a,
    input  wire logic [9:0]  dac_b,
    input  wire logic [9:0]  dac_c,
    input  wire logic [7:0]  status,
    output var  logic        ack,
    output var  logic [31:0] dat
);
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } cdsl_wb_t;
    cdsl_wb_t s_q, s_d;
    always_comb begin
        s_d     = s_q;
        s_d.ack = cyc && stb && !s_q.ack;
        s_d.dat = 32'h0000_0000;
        if (cyc && stb && !s_q.ack) begin
            case (adr)
                CDSL_OFS_DAC_A:  s_d.dat = {22'h000000, dac_a};
                CDSL_OFS_DAC_B:  s_d.dat = {22'h000000, dac_b};
                CDSL_OFS_DAC_C:  s_d.dat = {22'h000000, dac_c};
                CDSL_OFS_STATUS: s_d.dat = {24'h000000, status};
                default:         s_d.dat = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign ack = s_q.ack;
    assign dat = s_q.dat;
endmodule : cdsl_wb_slave
`default_nettype wire

// ---- testbench/cdsl_loader_chk.sv ----
// Purpose: port checks for the loader
// Assumes: host holds the strobe low over 6 cycles for every word
// Notes:   bound to every loader instance
`timescale 1ns/1ps
`default_nettype none
module cdsl_chk (
    input wire logic       CLOCK,
    input wire logic       SRST,
    input wire logic       SER_LOAD_N,
    input wire logic       WB_CYC_I,
    input wire logic       WB_STB_I,
    input wire logic       WB_ACK_O,
    input wire logic       FLAG_O,
    input wire logic       FLAG_OE,
    input wire logic [8:0] CONTROL_DAC_A,
    input wire logic [9:0] CONTROL_DAC_B,
    input wire logic [7:0] CONTROL_DAC_C,
    input wire logic [2:0] DAC_LOW_POWER
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);
    quiet_load_a: assert property ((!SER_LOAD_N)[*6] |=> $stable({CONTROL_DAC_A,
        CONTROL_DAC_B, CONTROL_DAC_C, FLAG_O, FLAG_OE})) else $error("output moved mid word");
    low_power_a: assert property (DAC_LOW_POWER == {&CONTROL_DAC_C || ~|CONTROL_DAC_C,
        &CONTROL_DAC_B || ~|CONTROL_DAC_B, &CONTROL_DAC_A || ~|CONTROL_DAC_A})
        else $error("low power flags wrong");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
    ack_follow_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack late");
    ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I)) else $error("stray ack");
    dac_commit_a: assert property ($changed(CONTROL_DAC_B) |-> $past(SER_LOAD_N, 3))
        else $error("code changed without strobe");
    flag_commit_a: assert property ($changed(FLAG_OE) |-> SER_LOAD_N && $past(SER_LOAD_N, 3))
        else $error("flag enable changed without strobe");
    reset_vals_a: assert property (disable iff (1'b0) SRST |=> CONTROL_DAC_A == 9'h0
        && DAC_LOW_POWER == 3'h7 && !FLAG_OE && !FLAG_O) else $error("reset values wrong");
endmodule : cdsl_chk
bind cdsl_loader cdsl_chk chk_i (
    .CLOCK         (CLOCK),
    .SRST          (SRST),
    .SER_LOAD_N    (SER_LOAD_N),
    .WB_CYC_I      (WB_CYC_I),
    .WB_STB_I      (WB_STB_I),
    .WB_ACK_O      (WB_ACK_O),
    .FLAG_O        (FLAG_O),
    .FLAG_OE       (FLAG_OE),
    .CONTROL_DAC_A (CONTROL_DAC_A),
    .CONTROL_DAC_B (CONTROL_DAC_B),
    .CONTROL_DAC_C (CONTROL_DAC_C),
    .DAC_LOW_POWER (DAC_LOW_POWER)
);
`default_nettype wire

// ---- testbench/cdsl_host.sv ----
// Purpose: host side of the three-wire load port
// Assumes: shift clock idles high, 400 ns period
// Notes:   data line shows the inverse of the last bit once released
`timescale 1ns/1ps
`default_nettype none
module cdsl_host (
    output var logic ser_clk,
    output var logic ser_data,
    output var logic ser_load_n
);
    initial begin
        ser_clk = 1'b1;
        ser_data = 1'b0;
        ser_load_n = 1'b1;
    end
    task automatic send(input logic [15:0] w);
        #113 ser_load_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            ser_data = w[i];
            #200 ser_clk = 1'b0;
            #200 ser_clk = 1'b1;
        end
        ser_data = ~w[0];
        #200 ser_load_n = 1'b1;
        #400;
    endtask : send
endmodule : cdsl_host
`default_nettype wire

// ---- testbench/testbench.sv ----
// Purpose: self-checking bench for the loader
// Assumes: reads answered within the watchdog span
// Notes:   expected codes kept in queues, popped by watchers
`timescale 1ns/1ps
`default_nettype none
module testbench
    import cdsl_pkg::*;
;
    logic        CLOCK = 0, SRST = 1, cyc = 0, stb = 0, we = 0, fo, foe, ack, sclk, sdat, sload;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic [8:0]  da, ea = 9'h0;
    logic [9:0]  db, eb = 10'h0;
    logic [7:0]  dc, ec = 8'h0;
    logic [2:0]  lp;
    logic [28:0] q[$];
    logic [31:0] wq[$];
    int          n_errors = 0, cmp_count = 0;
    cdsl_host host (.ser_clk(sclk), .ser_data(sdat), .ser_load_n(sload));
    cdsl_loader dut (.CLOCK(CLOCK), .SRST(SRST), .SER_CLK(sclk), .SER_DATA(sdat),
        .SER_LOAD_N(sload), .CONTROL_DAC_A(da), .CONTROL_DAC_B(db), .CONTROL_DAC_C(dc),
        .DAC_LOW_POWER(lp), .FLAG_O(fo), .FLAG_OE(foe), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_ACK_O(ack),
        .WB_DAT_O(rdat));
    initial forever #25 CLOCK = ~CLOCK;
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task automatic results;
        if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] e);
        @(posedge CLOCK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= $urandom;
        if (!w) wq.push_back(e);
        do @(posedge CLOCK); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    always @(posedge CLOCK) if (ack === 1'b1 && !we) cmp("read", wq.pop_front(), rdat);
    initial begin
        logic [28:0] e;
        // the strobe leaves x at time zero; that rise carries no word
        wait (SRST === 1'b0);
        forever begin
            @(posedge sload);
            repeat (6) @(posedge CLOCK);
            e = q.pop_front();
            cmp("outputs", {3'h0, e}, {3'h0, da, db, dc, fo, foe});
            cmp("low_power", {29'h0, &e[9:2] || ~|e[9:2], &e[19:10] || ~|e[19:10],
                &e[28:20] || ~|e[28:20]}, {29'h0, lp});
        end
    end
    initial begin
        #2_000_000 n_errors++;
        results;
    end
    initial begin
        logic [15:0] w;
        void'($urandom(32'h246A));
        repeat (4) @(posedge CLOCK);
        SRST <= 1'b0;
        for (int i = 0; i < 14; i++) begin
            w = 16'($urandom);
            if (i < 8) w[12:10] = 3'(i);
            if (i == 7) w[9:0] = 10'h3FF;
            if (i == 3) w[9:0] = 10'h000;
            if (w[11]) ea = w[8:0];
            if (w[12]) eb = w[9:0];
            if (w[10]) ec = w[7:0];
            q.push_back({ea, eb, ec, w[15], w[14]});
            host.send(w);
        end
        wb(1'b0, CDSL_OFS_DAC_B, {22'h0, eb});
        wb(1'b0, CDSL_OFS_DAC_C, {24'h0, ec});
        wb(1'b1, CDSL_OFS_DAC_A, 32'h0);
        wb(1'b0, CDSL_OFS_DAC_A, {23'h0, ea});
        wb(1'b0, CDSL_OFS_STATUS, {24'h0, 5'h00, w[14], w[15], 1'b0});
        wb(1'b0, 4'h1, 32'h0);
        repeat (2) @(posedge CLOCK);
        results;
    end
endmodule : testbench
`default_nettype wire
